// ### src/ftss_top.sv
// exception syndrome builder with wishbone register access and interrupt
//
// Behaviour
// RL1 - valid bit set when the six flags report the trapped exceptions.
// RL2 - multi-lane traps may clear the valid bit, selectable by software.
// RL3 - lane iteration field is all ones for traps from 32-bit state.
// RL4 - input denormal flag reports whether that exception occurred, when valid.
// RL5 - inexact flag reports whether that exception occurred, when valid.
// RL6 - underflow flag reports whether that exception occurred, when valid.
// RL7 - overflow flag reports whether that exception occurred, when valid.
// RL8 - divide-by-zero flag reports whether that exception occurred, when valid.
// RL9 - invalid operation flag reports whether that exception occurred, when valid.
// RL10 - each trap gated by its enable, 32-bit state uses the status-control enables.
// RL11 - selector bit high when lower bits hold implementation specific information.
// RL12 - without reliability extension and selector low, lower 24 bits are zero.
// RL13 - sync flag set only for synchronized, immediately taken error with matching code.
// RL14 - error state field carries the post-exception state for the matching code.
// RL15 - combined errors report the overall processor error state.
// RL16 - abort class bit gives an implementation classification for the matching code.
// RL17 - syndrome fields have no value software may rely on after reset.
// RL18 - reserved positions read as zero in both layouts. A software write to the syndrome word can set them.
//
// Our own choices: the register addresses and register access over Wishbone.
module ftss_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ftss_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fp_trap_req_i,
	input wire logic [ftss_pkg::FLAG_N-1:0] fp_raw_flags_i,
	input wire logic fp_state32_i,
	input wire logic fp_multilane_i,
	input wire logic serror_req_i,
	input wire logic impl_sel_i,
	input wire logic [ftss_pkg::IMPL_W-1:0] impl_info_i,
	input wire logic sync_event_i,
	input wire logic [2:0] err_state_i,
	input wire logic abort_class_i,
	input wire logic [ftss_pkg::STATUS_W-1:0] status_code_i,
	output logic fp_trap_taken_o,
	output logic [ftss_pkg::SYN_W-1:0] syndrome_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [ftss_pkg::CTRL_W-1:0] ctrl;
	logic [ftss_pkg::FLAG_N-1:0] fp_enable;
	logic [ftss_pkg::FLAG_N-1:0] fp_sc_enable;
	logic [ftss_pkg::SYN_W-1:0] syndrome;
	logic [ftss_pkg::IRQ_W-1:0] irq_status;
	logic [ftss_pkg::IRQ_W-1:0] irq_mask;
	logic [ftss_pkg::FLAG_N-1:0] trapped_flags;
	logic [ftss_pkg::SYN_W-1:0] enc_syn;

	// merge write data into an old word under the byte lanes
	function automatic logic [31:0] merge_word(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_v & ~mask) | (new_v & mask);
	endfunction : merge_word

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	// a write lands on the edge where the master sees ack, never earlier
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire wr_go = bus_req & wb_we_i & wb_ack_o;
	wire sel_ctrl = (wb_adr_i == ftss_pkg::OFF_CTRL);
	wire sel_fpe = (wb_adr_i == ftss_pkg::OFF_FP_ENABLE);
	wire sel_fpsc = (wb_adr_i == ftss_pkg::OFF_FP_SC_ENABLE);
	wire sel_syn = (wb_adr_i == ftss_pkg::OFF_SYNDROME);
	wire sel_ists = (wb_adr_i == ftss_pkg::OFF_IRQ_STATUS);
	wire sel_imsk = (wb_adr_i == ftss_pkg::OFF_IRQ_MASK);

	// unmapped addresses read as zero and swallow writes, but still ack
	wire [31:0] rd_word = sel_ctrl ? 32'(ctrl) :
		sel_fpe ? 32'(fp_enable) :
		sel_fpsc ? 32'(fp_sc_enable) :
		sel_syn ? 32'(syndrome) :
		sel_ists ? 32'(irq_status) :
		sel_imsk ? 32'(irq_mask) : 32'h00000000;

	wire [31:0] wr_ctrl = merge_word(32'(ctrl), wb_dat_i, wb_sel_i);
	wire [31:0] wr_fpe = merge_word(32'(fp_enable), wb_dat_i, wb_sel_i);
	wire [31:0] wr_fpsc = merge_word(32'(fp_sc_enable), wb_dat_i, wb_sel_i);
	wire [31:0] wr_syn = merge_word(32'(syndrome), wb_dat_i, wb_sel_i);
	wire [31:0] wr_imsk = merge_word(32'(irq_mask), wb_dat_i, wb_sel_i);
	wire [31:0] wr_clr = merge_word(32'h00000000, wb_dat_i, wb_sel_i);

	// one wait state: ack and read data register together, ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req & ~wb_ack_o) begin
				wb_dat_o <= rd_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	wire ras_present = ctrl[ftss_pkg::CTRL_RAS_BIT];
	wire error_sync_feature = ctrl[ftss_pkg::CTRL_SYNC_FEAT_BIT];
	wire lane_clr_en = ctrl[ftss_pkg::CTRL_LANE_CLR_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= ftss_pkg::CTRL_RST;
			fp_enable <= ftss_pkg::ENABLE_RST;
			fp_sc_enable <= ftss_pkg::ENABLE_RST;
			irq_mask <= ftss_pkg::IRQ_RST;
		end else if (wr_go) begin
			if (sel_ctrl) ctrl <= wr_ctrl[ftss_pkg::CTRL_W-1:0];
			if (sel_fpe) fp_enable <= wr_fpe[ftss_pkg::FLAG_N-1:0];
			if (sel_fpsc) fp_sc_enable <= wr_fpsc[ftss_pkg::FLAG_N-1:0];
			if (sel_imsk) irq_mask <= wr_imsk[ftss_pkg::IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// trap gating
	// ----------------------------------------------------------------
	// the enable bank follows the execution state of the trapping instruction
	genvar g;
	generate
		for (g = 0; g < ftss_pkg::FLAG_N; g++) begin : g_gate
			assign trapped_flags[g] = fp_raw_flags_i[g] &
				(fp_state32_i ? fp_sc_enable[g] : fp_enable[g]); // RL10
		end
	endgenerate

	assign fp_trap_taken_o = fp_trap_req_i & (|trapped_flags); // RL10

	// ----------------------------------------------------------------
	// syndrome capture
	// ----------------------------------------------------------------
	// a system error outranks a same-cycle fp trap; the core re-raises the trap later
	ftss_encoder ftss_encoder_inst (
		.is_serror_i(serror_req_i),
		.fp_flags_i(trapped_flags),
		.fp_state32_i(fp_state32_i),
		.fp_multilane_i(fp_multilane_i),
		.lane_clr_en_i(lane_clr_en),
		.ras_present_i(ras_present),
		.error_sync_feature_i(error_sync_feature),
		.impl_sel_i(impl_sel_i),
		.impl_info_i(impl_info_i),
		.sync_event_i(sync_event_i),
		.err_state_i(err_state_i), // overall state supplied by the core
		.abort_class_i(abort_class_i),
		.status_code_i(status_code_i),
		.syndrome_o(enc_syn)
	);

	wire capture = serror_req_i | fp_trap_taken_o;
	// hardware capture wins over a software write in the same cycle
	wire [ftss_pkg::SYN_W-1:0] next_syndrome = capture ? enc_syn :
		(wr_go & sel_syn) ? wr_syn[ftss_pkg::SYN_W-1:0] : syndrome;

	// reset value is a convenience only; handlers must not depend on it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			syndrome <= ftss_pkg::SYNDROME_RST; // RL17
		end else begin
			syndrome <= next_syndrome;
		end
	end

	assign syndrome_o = syndrome;

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// set beats write-one-to-clear so a record taken during the clear is not lost
	wire [ftss_pkg::IRQ_W-1:0] irq_events = {serror_req_i, fp_trap_taken_o};
	wire [ftss_pkg::IRQ_W-1:0] irq_clr = (wr_go & sel_ists) ?
		wr_clr[ftss_pkg::IRQ_W-1:0] : '0;
	wire [ftss_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_events;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= ftss_pkg::IRQ_RST;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_fp_rec;
		fp_trap_taken_o && !serror_req_i;
	endsequence

	sequence s_fp_valid_rec;
		s_fp_rec ##0 !(fp_multilane_i && lane_clr_en);
	endsequence

	sequence s_se_arch;
		serror_req_i && !impl_sel_i && ras_present;
	endsequence

	sequence s_se_match;
		s_se_arch ##0 (status_code_i == ftss_pkg::STATUS_SERROR);
	endsequence

	// architected record whose status code is not the system-error code
	sequence s_se_other;
		s_se_arch ##0 (status_code_i != ftss_pkg::STATUS_SERROR);
	endsequence

	property p_flag(int unsigned pos, int idx);
		s_fp_valid_rec |=> syndrome_o[pos] == $past(trapped_flags[idx]);
	endproperty

	// ----------------------------------------------------------------
	// floating-point trap record
	// ----------------------------------------------------------------
	a_fp_valid_set: assert property (s_fp_valid_rec |=> syndrome_o[ftss_pkg::FP_VALID_BIT]) // RL1
		else $error("valid bit low after an fp trap record");

	a_lane_clear: assert property (s_fp_rec ##0 (fp_multilane_i && lane_clr_en)
		|=> !syndrome_o[ftss_pkg::FP_VALID_BIT] && syndrome_o[7:0] == 8'h00) // RL2
		else $error("multi-lane trap did not clear valid and flags");

	a_lane_ones: assert property (s_fp_rec ##0 fp_state32_i
		|=> syndrome_o[ftss_pkg::LANE_LSB +: ftss_pkg::LANE_W] == 3'h7) // RL3
		else $error("lane field not all ones for 32-bit state");

	// the 64-bit state leaves the lane field clear, a local choice
	a_lane_zero: assert property (s_fp_rec ##0 !fp_state32_i
		|=> syndrome_o[ftss_pkg::LANE_LSB +: ftss_pkg::LANE_W] == 3'h0) // RL3
		else $error("lane field not clear for 64-bit state");

	// each flag bit follows its gated exception one cycle later
	a_denorm_flag: assert property (p_flag(7, 5)) // RL4
		else $error("input denormal flag mismatch");
	a_inexact_flag: assert property (p_flag(4, 4)) // RL5
		else $error("inexact flag mismatch");
	a_under_flag: assert property (p_flag(3, 3)) // RL6
		else $error("underflow flag mismatch");
	a_over_flag: assert property (p_flag(2, 2)) // RL7
		else $error("overflow flag mismatch");
	a_divzero_flag: assert property (p_flag(1, 1)) // RL8
		else $error("divide-by-zero flag mismatch");
	a_invalid_flag: assert property (p_flag(0, 0)) // RL9
		else $error("invalid operation flag mismatch");

	a_fp_reserved: assert property (s_fp_rec
		|=> !syndrome_o[24] && syndrome_o[22:11] == 12'h000
		&& syndrome_o[6:5] == 2'h0) // RL18
		else $error("reserved bits set in fp record");

	// ----------------------------------------------------------------
	// trap gating
	// ----------------------------------------------------------------
	a_trap_gated: assert property (fp_trap_req_i && fp_state32_i
		&& ((fp_raw_flags_i & fp_sc_enable) == 6'h00) |-> !fp_trap_taken_o) // RL10
		else $error("trap taken with its 32-bit enables clear");

	a_trap_gated64: assert property (fp_trap_req_i && !fp_state32_i
		&& ((fp_raw_flags_i & fp_enable) == 6'h00) |-> !fp_trap_taken_o) // RL10
		else $error("trap taken with its 64-bit enables clear");

	// an enabled exception must be taken, or its record would be lost
	a_trap_taken: assert property (fp_trap_req_i && !fp_state32_i
		&& ((fp_raw_flags_i & fp_enable) != 6'h00) |-> fp_trap_taken_o) // RL10
		else $error("enabled trap not taken");

	// ----------------------------------------------------------------
	// system error record
	// ----------------------------------------------------------------
	a_impl_select: assert property (serror_req_i && impl_sel_i
		|=> syndrome_o[ftss_pkg::SEL_BIT] && syndrome_o[23:0] == $past(impl_info_i)) // RL11
		else $error("implementation syndrome not recorded");

	a_no_ras_zero: assert property (serror_req_i && !impl_sel_i && !ras_present
		|=> syndrome_o == 25'h0000000) // RL12
		else $error("syndrome not zero without reliability extension");

	a_sync_flag: assert property (s_se_arch ##0
		(status_code_i != ftss_pkg::STATUS_SERROR || !error_sync_feature || !sync_event_i)
		|=> !syndrome_o[ftss_pkg::SYNC_FLAG_BIT]) // RL13
		else $error("sync flag set without a synchronized error");

	a_sync_set: assert property (s_se_match ##0 (error_sync_feature && sync_event_i)
		|=> syndrome_o[ftss_pkg::SYNC_FLAG_BIT]) // RL13
		else $error("sync flag clear for a synchronized error");

	a_err_state: assert property (s_se_match ##0 (err_state_i == 3'h2)
		|=> syndrome_o[12:10] == 3'h2 && irq_status[ftss_pkg::IRQ_SE_BIT]) // RL14
		else $error("error state field or status bit wrong");

	a_state_legal: assert property (s_se_arch |=> syndrome_o[12:10] != 3'h4
		&& syndrome_o[12:10] != 3'h5 && syndrome_o[12:10] != 3'h7) // RL15
		else $error("reserved error state reported");

	// state and abort class stay zero unless the code names a system error
	a_other_zero: assert property (s_se_other |=> syndrome_o[12:9] == 4'h0) // RL14 RL16
		else $error("error state or abort class set for another code");

	a_status_copy: assert property (s_se_arch
		|=> syndrome_o[5:0] == $past(status_code_i)) // RL11
		else $error("status code not recorded");

	a_abort_class: assert property (s_se_match
		|=> syndrome_o[ftss_pkg::ABORT_CLASS_BIT] == $past(abort_class_i)) // RL16
		else $error("abort class bit mismatch");

	a_se_reserved: assert property (s_se_arch |=> syndrome_o[23:14] == 10'h000) // RL18
		else $error("reserved bits set in system error record");

	// ----------------------------------------------------------------
	// interrupt status and bus
	// ----------------------------------------------------------------
	// a record taken during a clear must still leave its status bit set
	a_irq_fp_set: assert property (fp_trap_taken_o |=> irq_status[ftss_pkg::IRQ_FP_BIT])
		else $error("fp trap status bit not set");

	a_irq_se_set: assert property (serror_req_i |=> irq_status[ftss_pkg::IRQ_SE_BIT])
		else $error("system error status bit not set");

	a_ack_pulse: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single one-cycle answer");

endmodule : ftss_top

// ### src/ftss_pkg.sv
// constants, field layout and register map of the exception syndrome builder
package ftss_pkg;

	// ----------------------------------------------------------------
	// syndrome word layout
	// ----------------------------------------------------------------
	localparam int SYN_W = 25;
	localparam int FLAG_N = 6;
	localparam int FP_VALID_BIT = 23;
	localparam int LANE_LSB = 8;
	localparam int LANE_W = 3;
	localparam logic [2:0] LANE_ALL_ONES = 3'h7;
	// flag order: invalid op, divide zero, overflow, underflow, inexact, input denormal
	localparam int unsigned FLAG_POS [0:5] = '{0, 1, 2, 3, 4, 7};
	localparam int SEL_BIT = 24;
	localparam int IMPL_W = 24;
	localparam int SYNC_FLAG_BIT = 13;
	localparam int ERR_TYPE_LSB = 10;
	localparam int ERR_TYPE_W = 3;
	localparam int ABORT_CLASS_BIT = 9;
	localparam int STATUS_LSB = 0;
	localparam int STATUS_W = 6;
	localparam logic [5:0] STATUS_SERROR = 6'h11;

	// post-exception error state codes
	typedef enum logic [2:0] {
		ST_UNCONTAINABLE = 3'b000,
		ST_UNRECOVERABLE = 3'b001,
		ST_RESTARTABLE = 3'b010,
		ST_RECOVERABLE = 3'b011,
		ST_CORRECTED = 3'b110
	} ftss_err_state_t;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FP_ENABLE = 8'h04;
	localparam logic [7:0] OFF_FP_SC_ENABLE = 8'h08;
	localparam logic [7:0] OFF_SYNDROME = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	localparam int CTRL_W = 3;
	localparam int CTRL_RAS_BIT = 0;
	localparam int CTRL_SYNC_FEAT_BIT = 1;
	localparam int CTRL_LANE_CLR_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h3;
	localparam logic [5:0] ENABLE_RST = 6'h00;
	localparam logic [24:0] SYNDROME_RST = 25'h0000000;

	localparam int IRQ_W = 2;
	localparam int IRQ_FP_BIT = 0;
	localparam int IRQ_SE_BIT = 1;
	localparam logic [1:0] IRQ_RST = 2'h0;

endpackage : ftss_pkg

// ### src/ftss_encoder.sv
// combinational encoder of the two syndrome layouts
module ftss_encoder (
	input wire logic is_serror_i,
	input wire logic [ftss_pkg::FLAG_N-1:0] fp_flags_i,
	input wire logic fp_state32_i,
	input wire logic fp_multilane_i,
	input wire logic lane_clr_en_i,
	input wire logic ras_present_i,
	input wire logic error_sync_feature_i,
	input wire logic impl_sel_i,
	input wire logic [ftss_pkg::IMPL_W-1:0] impl_info_i,
	input wire logic sync_event_i,
	input wire logic [2:0] err_state_i,
	input wire logic abort_class_i,
	input wire logic [ftss_pkg::STATUS_W-1:0] status_code_i,
	output logic [ftss_pkg::SYN_W-1:0] syndrome_o
);

	// ----------------------------------------------------------------
	// shared decode
	// ----------------------------------------------------------------
	logic [ftss_pkg::SYN_W-1:0] fp_syn;
	logic [ftss_pkg::SYN_W-1:0] se_syn;
	logic [2:0] legal_state;
	wire fp_valid = !(fp_multilane_i && lane_clr_en_i); // RL2
	wire serror_code = (status_code_i == ftss_pkg::STATUS_SERROR);

	// reserved codes collapse to the worst state so software never sees a reserved value
	always_comb begin
		case (ftss_pkg::ftss_err_state_t'(err_state_i))
			ftss_pkg::ST_UNCONTAINABLE,
			ftss_pkg::ST_UNRECOVERABLE,
			ftss_pkg::ST_RESTARTABLE,
			ftss_pkg::ST_RECOVERABLE,
			ftss_pkg::ST_CORRECTED: legal_state = err_state_i; // RL14
			default: legal_state = ftss_pkg::ST_UNCONTAINABLE;
		endcase
	end

	// ----------------------------------------------------------------
	// floating-point trap layout
	// ----------------------------------------------------------------
	// flags are forced low when not valid; the zero default keeps reserved bits clean
	always_comb begin
		fp_syn = '0; // RL18
		fp_syn[ftss_pkg::FP_VALID_BIT] = fp_valid; // RL1
		if (fp_state32_i) begin
			fp_syn[ftss_pkg::LANE_LSB +: ftss_pkg::LANE_W] = ftss_pkg::LANE_ALL_ONES; // RL3
		end
		for (int i = 0; i < ftss_pkg::FLAG_N; i++) begin
			fp_syn[ftss_pkg::FLAG_POS[i]] = fp_valid & fp_flags_i[i]; // RL4 RL5 RL6 RL7 RL8 RL9
		end
	end

	// ----------------------------------------------------------------
	// system error layout
	// ----------------------------------------------------------------
	always_comb begin
		se_syn = '0; // RL18
		if (impl_sel_i) begin
			se_syn[ftss_pkg::SEL_BIT] = 1'b1; // RL11
			se_syn[ftss_pkg::IMPL_W-1:0] = impl_info_i;
		end else if (ras_present_i) begin // RL12
			se_syn[ftss_pkg::SYNC_FLAG_BIT] = error_sync_feature_i & serror_code &
				sync_event_i; // RL13
			if (serror_code) begin
				se_syn[ftss_pkg::ERR_TYPE_LSB +: ftss_pkg::ERR_TYPE_W] = legal_state; // RL14 RL15
			end
			se_syn[ftss_pkg::ABORT_CLASS_BIT] = serror_code & abort_class_i; // RL16
			se_syn[ftss_pkg::STATUS_LSB +: ftss_pkg::STATUS_W] = status_code_i;
		end
	end

	assign syndrome_o = is_serror_i ? se_syn : fp_syn;

endmodule : ftss_encoder

// ### tb/ftss_top_test.sv
// self-checking bench of the exception syndrome builder over its register bus
module ftss_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// stimulus, observed outputs and bookkeeping
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic fp_trap_req_i = 1'b0;
	logic [5:0] fp_raw_flags_i = 6'h00;
	logic fp_state32_i = 1'b0;
	logic fp_multilane_i = 1'b0;
	logic serror_req_i = 1'b0;
	logic impl_sel_i = 1'b0;
	logic [23:0] impl_info_i = 24'h0;
	logic sync_event_i = 1'b0;
	logic [2:0] err_state_i = 3'h0;
	logic abort_class_i = 1'b0;
	logic [5:0] status_code_i = 6'h00;
	logic fp_trap_taken_o;
	logic [24:0] syndrome_o;
	logic irq_o;
	int n_fail = 0;
	int n_tests = 0;
	int k;
	logic [31:0] rd;
	logic taken;
	// reserved state code 3'h4 must be recorded as uncontainable
	logic [2:0] st_in [0:5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4};
	logic [2:0] st_exp [0:5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h0};

	always #10 clk_i = ~clk_i;

	ftss_top ftss_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fp_trap_req_i(fp_trap_req_i),
		.fp_raw_flags_i(fp_raw_flags_i), .fp_state32_i(fp_state32_i),
		.fp_multilane_i(fp_multilane_i), .serror_req_i(serror_req_i),
		.impl_sel_i(impl_sel_i), .impl_info_i(impl_info_i), .sync_event_i(sync_event_i),
		.err_state_i(err_state_i), .abort_class_i(abort_class_i),
		.status_code_i(status_code_i), .fp_trap_taken_o(fp_trap_taken_o),
		.syndrome_o(syndrome_o), .irq_o(irq_o)
	);

	// ----------------------------------------------------------------
	// comparison, reporting and end of run
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic tdone(input string name);
		$display("test %s finished, mismatches so far %0d", name, n_fail);
	endtask : tdone

	// ----------------------------------------------------------------
	// bus access: request held until ack is sampled, then released
	// ----------------------------------------------------------------
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			input logic [3:0] sel);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			$display("bus answer missing at %0t ns", $time);
			wrap_up();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_cycle

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		wb_cycle(1'b1, adr, dat, sel);
	endtask : wr

	task automatic rdx(input logic [7:0] adr, input logic [31:0] exp);
		wb_cycle(1'b0, adr, 32'h0, 4'hF);
		chk(rd, exp);
	endtask : rdx

	// ----------------------------------------------------------------
	// event pulses: fields ride with the one-cycle request
	// ----------------------------------------------------------------
	task automatic pulse(input logic fp, input logic se);
		fp_trap_req_i <= fp;
		serror_req_i <= se;
		@(posedge clk_i);
		taken = fp_trap_taken_o;
		fp_trap_req_i <= 1'b0;
		serror_req_i <= 1'b0;
		@(posedge clk_i);
	endtask : pulse

	task automatic fp_ev(input logic [5:0] raw, input logic s32, input logic ml);
		fp_raw_flags_i <= raw;
		fp_state32_i <= s32;
		fp_multilane_i <= ml;
		pulse(1'b1, 1'b0);
	endtask : fp_ev

	task automatic se_ev(input logic sel, input logic [23:0] info, input logic sy,
			input logic [2:0] st, input logic ab, input logic [5:0] code);
		impl_sel_i <= sel;
		impl_info_i <= info;
		sync_event_i <= sy;
		err_state_i <= st;
		abort_class_i <= ab;
		status_code_i <= code;
		pulse(1'b0, 1'b1);
	endtask : se_ev

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset state and an unmapped word that must stay zero
		chk({7'h00, syndrome_o}, 32'h0);
		rdx(ftss_pkg::OFF_CTRL, 32'h3);
		rdx(ftss_pkg::OFF_FP_ENABLE, 32'h0);
		rdx(ftss_pkg::OFF_FP_SC_ENABLE, 32'h0);
		rdx(ftss_pkg::OFF_IRQ_STATUS, 32'h0);
		rdx(ftss_pkg::OFF_IRQ_MASK, 32'h0);
		wr(8'h18, 32'hFFFFFFFF, 4'hF);
		rdx(8'h18, 32'h0);
		tdone("reset");
		// each flag alone, then all together, from the 64-bit state
		wr(ftss_pkg::OFF_FP_ENABLE, 32'h3F, 4'hF);
		for (k = 0; k < 6; k++) begin
			fp_ev(6'h01 << k, 1'b0, 1'b0);
			chk({31'h0, taken}, 32'h1);
			chk({7'h00, syndrome_o}, 32'h0080_0000 | (32'h1 << ftss_pkg::FLAG_POS[k]));
		end
		fp_ev(6'h3F, 1'b0, 1'b0);
		chk({7'h00, syndrome_o}, 32'h0080_009F);
		tdone("flags");
		// trap gating by the bank of the current state, lane field in 32-bit state
		wr(ftss_pkg::OFF_FP_ENABLE, 32'h01, 4'hF);
		wr(ftss_pkg::OFF_FP_SC_ENABLE, 32'h3E, 4'hF);
		fp_ev(6'h3E, 1'b0, 1'b0);
		chk({31'h0, taken}, 32'h0);
		chk({7'h00, syndrome_o}, 32'h0080_009F);
		fp_ev(6'h3F, 1'b1, 1'b0);
		chk({31'h0, taken}, 32'h1);
		chk({7'h00, syndrome_o}, 32'h0080_079E);
		tdone("gating");
		// multi-lane trap with valid clearing on, then off
		wr(ftss_pkg::OFF_CTRL, 32'h7, 4'hF);
		fp_ev(6'h01, 1'b0, 1'b1);
		chk({7'h00, syndrome_o}, 32'h0);
		wr(ftss_pkg::OFF_CTRL, 32'h3, 4'hF);
		fp_ev(6'h01, 1'b0, 1'b1);
		chk({7'h00, syndrome_o}, 32'h0080_0001);
		tdone("multilane");
		// interrupt: pending but masked, unmasked, then cleared by writing one
		rdx(ftss_pkg::OFF_IRQ_STATUS, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		wr(ftss_pkg::OFF_IRQ_MASK, 32'h3, 4'hF);
		rdx(ftss_pkg::OFF_IRQ_MASK, 32'h3);
		chk({31'h0, irq_o}, 32'h1);
		wr(ftss_pkg::OFF_IRQ_STATUS, 32'h1, 4'hF);
		rdx(ftss_pkg::OFF_IRQ_STATUS, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		tdone("interrupt");
		// system errors: every state code plus one reserved, other status code
		for (k = 0; k < 6; k++) begin
			se_ev(1'b0, 24'h0, 1'b1, st_in[k], k[0], 6'h11);
			chk({7'h00, syndrome_o}, 32'h2011 | ({29'h0, st_exp[k]} << 10) | (32'(k[0]) << 9));
		end
		se_ev(1'b0, 24'h0, 1'b1, 3'h3, 1'b1, 6'h00);
		chk({7'h00, syndrome_o}, 32'h0);
		se_ev(1'b1, 24'hABCDEF, 1'b1, 3'h3, 1'b1, 6'h11);
		chk({7'h00, syndrome_o}, 32'h01AB_CDEF);
		wr(ftss_pkg::OFF_CTRL, 32'h1, 4'hF);
		se_ev(1'b0, 24'h0, 1'b1, 3'h1, 1'b0, 6'h11);
		chk({7'h00, syndrome_o}, 32'h0411);
		wr(ftss_pkg::OFF_CTRL, 32'h0, 4'hF);
		se_ev(1'b0, 24'h0, 1'b1, 3'h1, 1'b1, 6'h11);
		chk({7'h00, syndrome_o}, 32'h0);
		rdx(ftss_pkg::OFF_IRQ_STATUS, 32'h2);
		chk({31'h0, irq_o}, 32'h1);
		wr(ftss_pkg::OFF_IRQ_STATUS, 32'h3, 4'hF);
		tdone("system error");
		// both events in one cycle: the system error is recorded, both flagged
		impl_sel_i <= 1'b1;
		impl_info_i <= 24'h123456;
		fp_raw_flags_i <= 6'h01;
		fp_state32_i <= 1'b0;
		fp_multilane_i <= 1'b0;
		pulse(1'b1, 1'b1);
		chk({7'h00, syndrome_o}, 32'h0112_3456);
		rdx(ftss_pkg::OFF_IRQ_STATUS, 32'h3);
		tdone("collision");
		// software access to the syndrome word, with byte lanes
		wr(ftss_pkg::OFF_SYNDROME, 32'hFFFFFFFF, 4'hF);
		rdx(ftss_pkg::OFF_SYNDROME, 32'h01FF_FFFF);
		wr(ftss_pkg::OFF_SYNDROME, 32'h0, 4'h2);
		rdx(ftss_pkg::OFF_SYNDROME, 32'h01FF_00FF);
		chk({7'h00, syndrome_o}, 32'h01FF_00FF);
		tdone("syndrome access");
		wrap_up();
	end

endmodule : ftss_top_test
